// ==== design/pfc_pkg.sv ====
// pfc_pkg: shared constants of the pause flow control block
// assumes one 100 MHz clock; registers on apb, index times four
package pfc_pkg;
  // clock and pause quantum timing
  localparam int unsigned CLK_PERIOD_PS   = 10000;
  localparam int unsigned BIT_TIME_PS     = 25;
  localparam int unsigned QUANTUM_BITS    = 512;
  localparam int unsigned CYC_PER_QUANTUM =
    (QUANTUM_BITS * BIT_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // register indices and byte addresses
  localparam int unsigned REG_CTRL_IDX   = 'h0700;
  localparam int unsigned REG_QUANTA_IDX = 'h0701;
  localparam int unsigned REG_STATUS_IDX = 'h0702;
  localparam int unsigned REG_ADDRL_IDX  = 'h0707;
  localparam int unsigned REG_ADDRH_IDX  = 'h0708;
  localparam int unsigned APB_AW         = 16;
  localparam logic [15:0] REG_CTRL_ADDR   = 16'(REG_CTRL_IDX * 4);
  localparam logic [15:0] REG_QUANTA_ADDR = 16'(REG_QUANTA_IDX * 4);
  localparam logic [15:0] REG_STATUS_ADDR = 16'(REG_STATUS_IDX * 4);
  localparam logic [15:0] REG_ADDRL_ADDR  = 16'(REG_ADDRL_IDX * 4);
  localparam logic [15:0] REG_ADDRH_ADDR  = 16'(REG_ADDRH_IDX * 4);

  // control register fields
  localparam int unsigned CTRL_PROC_BIT   = 0;
  localparam int unsigned CTRL_FWD_BIT    = 1;
  localparam int unsigned CTRL_OBEY_BIT   = 2;
  localparam int unsigned CTRL_RETX_BIT   = 3;
  localparam int unsigned CTRL_PEN_LSB    = 8;
  localparam logic [31:0] CTRL_MASK       = 32'h0000_FF0F;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_FF05;
  // quanta register: tx quanta low half, hold-off high half
  localparam int unsigned QUANTA_HOLD_LSB = 16;
  localparam logic [31:0] QUANTA_RESET    = 32'h0100_FFFF;
  localparam logic [31:0] ADDRL_RESET     = 32'h0000_0000;
  localparam logic [15:0] ADDRH_RESET     = 16'h0000;
  // status register fields
  localparam int unsigned STAT_REQ_LSB    = 8;
  localparam int unsigned STAT_HOLD_LSB   = 16;

  // mac control frame constants
  localparam logic [15:0] ETYPE_MAC_CTRL  = 16'h8808;
  localparam logic [15:0] OPC_STD_PAUSE   = 16'h0001;
  localparam logic [15:0] OPC_PRIO_PAUSE  = 16'h0101;
  localparam logic [47:0] PAUSE_MCAST     = 48'h0180_C200_0001;
  localparam int unsigned QW              = 16;
  localparam int unsigned MAX_CLASS       = 8;
endpackage

// ==== design/pfc_quanta_timer.sv ====
// pfc_quanta_timer: per-class pause hold counter in quanta
// assumes tick is a one-cycle pulse per pause quantum
`timescale 1ns/1ps
`default_nettype none
module pfc_quanta_timer (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // quantum tick and new value
  input  wire logic        tick,
  input  wire logic        load,
  input  wire logic [15:0] loadValue,
  // state
  output logic             active,
  output logic [15:0]      count
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = loadValue;
    end else if (tick && cnt_q != 16'h0000) begin
      cnt_d = cnt_q - 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign count  = cnt_q;
  assign active = cnt_q != 16'h0000;

  a_zero_resumes: assert property (@(posedge ref_clk) disable iff (!nrst)
    load && loadValue == 16'h0000 |=> !active)
    else $error("zero quanta did not end the pause");
  a_last_governs: assert property (@(posedge ref_clk) disable iff (!nrst)
    load |=> count == $past(loadValue))
    else $error("new pause value did not replace count");
endmodule
`default_nettype wire

// ==== design/pfc_rx_screen.sv ====
// pfc_rx_screen: screens received frame headers for pause frames
// assumes one header pulse per frame, fields valid with it
`timescale 1ns/1ps
`default_nettype none
module pfc_rx_screen #(
  parameter int unsigned NUM_CLASS = 8,
  parameter bit          PFC_MODE  = 1'b1
) (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       nrst,
  // received header
  input  wire logic                       hdrValid,
  input  wire logic [47:0]                destAddr,
  input  wire logic [15:0]                etherType,
  input  wire logic [15:0]                opcode,
  input  wire logic                       lengthOk,
  input  wire logic [7:0]                 prioEnable,
  input  wire logic [NUM_CLASS*16-1:0]    quantaIn,
  // configuration
  input  wire logic [47:0]                matchAddr,
  input  wire logic                       procEn,
  input  wire logic                       fwdEn,
  // decisions
  output logic                            deliverValid,
  output logic                            deliver,
  output logic [NUM_CLASS-1:0]            loadValid,
  output logic [NUM_CLASS*16-1:0]         loadQuanta
);
  localparam logic [15:0] OPC = PFC_MODE ? pfc_pkg::OPC_PRIO_PAUSE : pfc_pkg::OPC_STD_PAUSE;

  logic isPause;
  logic match;
  assign isPause = etherType == pfc_pkg::ETYPE_MAC_CTRL && opcode == OPC && lengthOk;
  assign match   = destAddr == matchAddr || destAddr == pfc_pkg::PAUSE_MCAST;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      deliverValid <= 1'b0;
      deliver      <= 1'b0;
    end else begin
      deliverValid <= hdrValid;
      // matched pause dropped unless processed and forwarded
      deliver      <= !(isPause && match && !(procEn && fwdEn));
    end
  end

  // fwdEn never reaches the load path
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      loadValid  <= '0;
      loadQuanta <= '0;
    end else begin
      loadQuanta <= quantaIn;
      for (int n = 0; n < NUM_CLASS; n++) begin
        loadValid[n] <= hdrValid && procEn && isPause && match &&
                        (!PFC_MODE || prioEnable[n]);
      end
    end
  end

  a_drop_matched: assert property (@(posedge ref_clk) disable iff (!nrst)
    hdrValid && isPause && match && !(procEn && fwdEn) |=> deliverValid && !deliver)
    else $error("matched pause frame reached the client");
  a_pass_unmatched: assert property (@(posedge ref_clk) disable iff (!nrst)
    hdrValid && !match |=> deliverValid && deliver)
    else $error("unmatched frame was dropped");
  a_off_no_effect: assert property (@(posedge ref_clk) disable iff (!nrst)
    !procEn |=> loadValid == '0)
    else $error("pause loaded while processing disabled");
endmodule
`default_nettype wire

// ==== design/pfc_flow_ctrl.sv ====
// pfc_flow_ctrl: pause generation, pause hold and rx pause screening
// assumes client inputs on ref_clk, apb master on ref_clk
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module pfc_flow_ctrl #(
  parameter bit          PFC_MODE  = 1'b1,
  parameter int unsigned NUM_CLASS = 8
) (
  // clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      nrst,
  // apb slave
  input  wire logic [15:0]               paddr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  // tx client pause request and hold
  input  wire logic [NUM_CLASS-1:0]      pauseInsertTx,
  input  wire logic                      txFrameActive,
  output logic [NUM_CLASS-1:0]           txHold,
  // control frame request to tx datapath
  output logic                           ctrlReqValid,
  input  wire logic                      ctrlReqReady,
  output logic                           ctrlReqXon,
  output logic [2:0]                     ctrlReqClass,
  output logic [15:0]                    ctrlReqQuanta,
  // received frame header
  input  wire logic                      rxHdrValid,
  input  wire logic [47:0]               rxDestAddr,
  input  wire logic [15:0]               rxEtherType,
  input  wire logic [15:0]               rxOpcode,
  input  wire logic                      rxLengthOk,
  input  wire logic [7:0]                rxPrioEnable,
  input  wire logic [NUM_CLASS*16-1:0]   rxQuanta,
  // rx decisions
  output logic                           rxDeliverValid,
  output logic                           rxDeliver,
  output logic [NUM_CLASS-1:0]           pauseReceiveRx
);
  localparam int unsigned QCW = $clog2(pfc_pkg::CYC_PER_QUANTUM + 1);

  // class count must fit mode and field widths
  if ((!PFC_MODE && NUM_CLASS != 1) || NUM_CLASS < 1 || NUM_CLASS > pfc_pkg::MAX_CLASS) begin : g_bad_cfg
    $error("NUM_CLASS must be 1 in standard mode and 1..8 otherwise");
  end

  // ---- apb register file
  logic [31:0] ctrl_q;
  logic [31:0] quanta_q;
  logic [31:0] addrLow_q;
  logic [15:0] addrHigh_q;
  logic [31:0] prdata_q;
  logic        setup;
  logic        access;

  function automatic logic [2:0] regDecode(input logic [15:0] a);
    unique case (a)
      pfc_pkg::REG_CTRL_ADDR:   regDecode = 3'd0;
      pfc_pkg::REG_QUANTA_ADDR: regDecode = 3'd1;
      pfc_pkg::REG_STATUS_ADDR: regDecode = 3'd2;
      pfc_pkg::REG_ADDRL_ADDR:  regDecode = 3'd3;
      pfc_pkg::REG_ADDRH_ADDR:  regDecode = 3'd4;
      default:                  regDecode = 3'd7;
    endcase
  endfunction

  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign pready  = 1'b1;
  assign pslverr = access && regDecode(paddr) == 3'd7;
  assign prdata  = prdata_q;

  logic        procEn;
  logic        fwdEn;
  logic        obeyOk;
  logic        retxEn;
  logic [7:0]  pauseEn;
  logic [15:0] txQuanta;
  logic [15:0] holdOff;
  assign procEn   = ctrl_q[pfc_pkg::CTRL_PROC_BIT];
  assign fwdEn    = ctrl_q[pfc_pkg::CTRL_FWD_BIT];
  assign obeyOk   = PFC_MODE || ctrl_q[pfc_pkg::CTRL_OBEY_BIT];
  assign retxEn   = ctrl_q[pfc_pkg::CTRL_RETX_BIT];
  assign pauseEn  = ctrl_q[pfc_pkg::CTRL_PEN_LSB +: 8];
  assign txQuanta = quanta_q[15:0];
  assign holdOff  = quanta_q[pfc_pkg::QUANTA_HOLD_LSB +: 16];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q     <= pfc_pkg::CTRL_RESET;
      quanta_q   <= pfc_pkg::QUANTA_RESET;
      addrLow_q  <= pfc_pkg::ADDRL_RESET;
      addrHigh_q <= pfc_pkg::ADDRH_RESET;
    end else if (access && pwrite) begin
      unique case (regDecode(paddr))
        3'd0:    ctrl_q     <= pwdata & pfc_pkg::CTRL_MASK;
        3'd1:    quanta_q   <= pwdata;
        3'd3:    addrLow_q  <= pwdata;
        3'd4:    addrHigh_q <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      prdata_q <= 32'h0000_0000;
      unique case (regDecode(paddr))
        3'd0:    prdata_q <= ctrl_q;
        3'd1:    prdata_q <= quanta_q;
        3'd2: begin
          prdata_q[NUM_CLASS-1:0]                          <= pauseReceiveRx;
          prdata_q[pfc_pkg::STAT_REQ_LSB +: NUM_CLASS]     <= pauseInsertTx;
          prdata_q[pfc_pkg::STAT_HOLD_LSB +: NUM_CLASS]    <= txHold;
        end
        3'd3:    prdata_q <= addrLow_q;
        3'd4:    prdata_q <= {16'h0000, addrHigh_q};
        default: ;
      endcase
    end
  end

  // ---- pause quantum tick
  logic [QCW-1:0] qdiv_q;
  logic           qtick;
  assign qtick = qdiv_q == QCW'(pfc_pkg::CYC_PER_QUANTUM - 1);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      qdiv_q <= '0;
    end else begin
      qdiv_q <= qtick ? '0 : qdiv_q + QCW'(1);
    end
  end

  // ---- rx screening and per-class hold timers
  logic [NUM_CLASS-1:0]    loadValid;
  logic [NUM_CLASS*16-1:0] loadQuanta;
  logic [NUM_CLASS-1:0]    timerActive;

  pfc_rx_screen #(
    .NUM_CLASS (NUM_CLASS),
    .PFC_MODE  (PFC_MODE)
  ) u_screen (
    .ref_clk      (ref_clk),
    .nrst         (nrst),
    .hdrValid     (rxHdrValid),
    .destAddr     (rxDestAddr),
    .etherType    (rxEtherType),
    .opcode       (rxOpcode),
    .lengthOk     (rxLengthOk),
    .prioEnable   (rxPrioEnable),
    .quantaIn     (rxQuanta),
    .matchAddr    ({addrHigh_q, addrLow_q}),
    .procEn       (procEn),
    .fwdEn        (fwdEn),
    .deliverValid (rxDeliverValid),
    .deliver      (rxDeliver),
    .loadValid    (loadValid),
    .loadQuanta   (loadQuanta)
  );

  logic [NUM_CLASS-1:0] hold_q;

  for (genvar n = 0; n < NUM_CLASS; n++) begin : g_hold
    pfc_quanta_timer u_timer (
      .ref_clk   (ref_clk),
      .nrst      (nrst),
      .tick      (qtick),
      .load      (loadValid[n]),
      .loadValue (loadQuanta[n*16 +: 16]),
      .active    (timerActive[n]),
      .count     ()
    );

    // hold only starts between frames
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        hold_q[n] <= 1'b0;
      end else begin
        hold_q[n] <= timerActive[n] && obeyOk && (hold_q[n] || !txFrameActive);
      end
    end
  end

  assign pauseReceiveRx = timerActive;
  assign txHold         = hold_q;

  // ---- xoff / xon generation
  logic [NUM_CLASS-1:0] reqPrev_q;
  logic [NUM_CLASS-1:0] xoffPend_q;
  logic [NUM_CLASS-1:0] xonPend_q;
  logic [15:0]          holdCnt_q [NUM_CLASS];
  logic [NUM_CLASS-1:0] grant;
  logic                 issue;

  function automatic logic [NUM_CLASS-1:0] firstOne(input logic [NUM_CLASS-1:0] v);
    firstOne = '0;
    for (int i = NUM_CLASS - 1; i >= 0; i--) begin
      if (v[i]) begin
        firstOne = '0;
        firstOne[i] = 1'b1;
      end
    end
  endfunction

  assign issue = !ctrlReqValid && |(xoffPend_q | xonPend_q) && !txFrameActive;
  assign grant = issue ? firstOne(xoffPend_q | xonPend_q) : '0;

  for (genvar n = 0; n < NUM_CLASS; n++) begin : g_gen
    logic rise;
    logic fall;
    logic retxDue;
    // request sampled directly, it is already on this clock
    assign rise    = pauseInsertTx[n] && !reqPrev_q[n];
    assign fall    = !pauseInsertTx[n] && reqPrev_q[n];
    assign retxDue = retxEn && pauseInsertTx[n] && reqPrev_q[n] &&
                     holdCnt_q[n] == 16'h0000 && !xoffPend_q[n];

    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        reqPrev_q[n]  <= 1'b0;
        xoffPend_q[n] <= 1'b0;
        xonPend_q[n]  <= 1'b0;
      end else begin
        reqPrev_q[n] <= pauseInsertTx[n];
        // grant clears first so a new edge wins
        if (grant[n]) begin
          xoffPend_q[n] <= 1'b0;
          xonPend_q[n]  <= 1'b0;
        end
        if ((rise && pauseEn[n]) || retxDue) begin
          xoffPend_q[n] <= 1'b1;
          xonPend_q[n]  <= 1'b0;
        end else if (fall) begin
          xonPend_q[n]  <= 1'b1;
          xoffPend_q[n] <= 1'b0;
        end
      end
    end

    // hold-off counts quanta since the last xoff issued
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        holdCnt_q[n] <= 16'h0000;
      end else if (grant[n] && xoffPend_q[n]) begin
        holdCnt_q[n] <= holdOff;
      end else if (qtick && holdCnt_q[n] != 16'h0000) begin
        holdCnt_q[n] <= holdCnt_q[n] - 16'h0001;
      end
    end
  end

  // request register toward the tx datapath
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrlReqValid  <= 1'b0;
      ctrlReqXon    <= 1'b0;
      ctrlReqClass  <= 3'd0;
      ctrlReqQuanta <= 16'h0000;
    end else if (issue) begin
      ctrlReqValid  <= 1'b1;
      ctrlReqXon    <= !(|(grant & xoffPend_q));
      ctrlReqQuanta <= |(grant & xoffPend_q) ? txQuanta : 16'h0000;
      ctrlReqClass  <= 3'd0;
      for (int i = 0; i < NUM_CLASS; i++) begin
        if (grant[i]) begin
          ctrlReqClass <= 3'(i);
        end
      end
    end else if (ctrlReqReady) begin
      ctrlReqValid <= 1'b0;
    end
  end

  // ---- checks
  sequence s_req_rise;
    $rose(pauseInsertTx[0]) && pauseEn[0];
  endsequence
  sequence s_xoff_issued;
    ##1 (ctrlReqValid && !ctrlReqXon && ctrlReqClass == 3'd0);
  endsequence

  a_xoff_on_rise: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_req_rise |=> xoffPend_q[0])
    else $error("no xoff pending after request rise");
  a_xoff_reaches: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_req_rise ##1 (!txFrameActive && !ctrlReqValid) |-> s_xoff_issued)
    else $error("xoff not issued while tx idle");
  a_xoff_quanta: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(ctrlReqValid) && !ctrlReqXon |-> ctrlReqQuanta == $past(txQuanta))
    else $error("xoff carries wrong quanta");
  a_xon_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
    ctrlReqValid && ctrlReqXon |-> ctrlReqQuanta == 16'h0000)
    else $error("xon carries nonzero quanta");
  a_xon_on_fall: assert property (@(posedge ref_clk) disable iff (!nrst)
    $fell(pauseInsertTx[0]) |=> xonPend_q[0] && !xoffPend_q[0])
    else $error("no xon pending after request fall");
  a_retx_due: assert property (@(posedge ref_clk) disable iff (!nrst)
    retxEn && pauseInsertTx[0] && $past(pauseInsertTx[0]) && holdCnt_q[0] == 16'h0000 |=> xoffPend_q[0] ||
    (ctrlReqValid && ctrlReqClass == 3'd0 && !ctrlReqXon))
    else $error("retransmit xoff missing");
  a_req_idle_only: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(ctrlReqValid) |-> $past(!txFrameActive))
    else $error("control frame request raised mid-frame");
  a_hold_idle_only: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(txHold[0]) |-> $past(!txFrameActive && timerActive[0]))
    else $error("hold started mid-frame");
  a_obey_off: assert property (@(posedge ref_clk) disable iff (!nrst)
    !obeyOk |=> txHold == '0)
    else $error("hold while obey bit clear");
  a_req_stable: assert property (@(posedge ref_clk) disable iff (!nrst)
    ctrlReqValid && !ctrlReqReady |=> ctrlReqValid && $stable(ctrlReqXon) && $stable(ctrlReqClass))
    else $error("control request changed before taken");
endmodule
`default_nettype wire

// ==== bench/pfc_tx_partner.sv ====
// pfc_tx_partner: tx datapath side of the control request port
// assumes requests on ref_clk; lat sets the stall before each grant
`timescale 1ns/1ps
`default_nettype none
module pfc_tx_partner (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  // control request port
  input  wire logic       ctrlReqValid,
  output logic            ctrlReqReady,
  // stall length in cycles
  input  wire logic [3:0] lat
);
  logic [3:0] waitCnt_q;
  // grant one request after lat cycles, ready only for that edge
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      waitCnt_q    <= '0;
      ctrlReqReady <= 1'b0;
    end else begin
      ctrlReqReady <= 1'b0;
      if (ctrlReqValid && !ctrlReqReady) begin
        if (waitCnt_q >= lat) begin
          ctrlReqReady <= 1'b1;
          waitCnt_q    <= '0;
        end else begin
          waitCnt_q <= waitCnt_q + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== bench/pfc_flow_ctrl_tb.sv ====
// pfc_flow_ctrl_tb: self-checking bench of the pause flow control block
// assumes default priority mode with 8 classes
`timescale 1ns/1ps
`default_nettype none
module pfc_flow_ctrl_tb;
  logic         ref_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic         txFrameActive = 0, rxHdrValid = 0, rxLengthOk = 1;
  logic         pready, pslverr, ctrlReqValid, ctrlReqReady, ctrlReqXon, rxDeliverValid, rxDeliver;
  logic [15:0]  paddr = '0, rxEtherType = '0, rxOpcode = '0, ctrlReqQuanta, txQ, q;
  logic [31:0]  pwdata = '0, prdata, rd, ctl;
  logic [7:0]   pauseInsertTx = '0, rxPrioEnable = '0, txHold, pauseReceiveRx, hold = '0;
  logic [47:0]  rxDestAddr = '0, mAddr;
  logic [127:0] rxQuanta = '0;
  logic [2:0]   ctrlReqClass;
  logic [3:0]   lat = '0;
  logic [19:0]  gotQ[$];
  int           n_fail = 0, checked = 0, seed = 60003;

  always #5 ref_clk = ~ref_clk;

  pfc_flow_ctrl dut (.ref_clk(ref_clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pauseInsertTx(pauseInsertTx), .txFrameActive(txFrameActive), .txHold(txHold),
    .ctrlReqValid(ctrlReqValid), .ctrlReqReady(ctrlReqReady), .ctrlReqXon(ctrlReqXon),
    .ctrlReqClass(ctrlReqClass), .ctrlReqQuanta(ctrlReqQuanta), .rxHdrValid(rxHdrValid),
    .rxDestAddr(rxDestAddr), .rxEtherType(rxEtherType), .rxOpcode(rxOpcode), .rxLengthOk(rxLengthOk),
    .rxPrioEnable(rxPrioEnable), .rxQuanta(rxQuanta), .rxDeliverValid(rxDeliverValid),
    .rxDeliver(rxDeliver), .pauseReceiveRx(pauseReceiveRx));
  pfc_tx_partner tp (.ref_clk(ref_clk), .nrst(nrst), .ctrlReqValid(ctrlReqValid),
    .ctrlReqReady(ctrlReqReady), .lat(lat));

  // record every granted control request
  always @(posedge ref_clk) if (ctrlReqValid === 1'b1 && ctrlReqReady === 1'b1)
    gotQ.push_back({ctrlReqXon, ctrlReqClass, ctrlReqQuanta});

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, output logic e);
    @(posedge ref_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic e;
    apb(1, a, d, e);
  endtask

  task automatic rdc(input logic [15:0] a, input logic [31:0] x, input logic ex);
    logic e;
    apb(0, a, 0, e);
    check(rd, x);
    check(e, ex);
  endtask

  task automatic expect_req(input logic [19:0] x);
    int k;
    k = 0;
    while (gotQ.size() == 0 && k < 300) begin @(posedge ref_clk); k++; end
    if (gotQ.size() == 0) check(0, 1);
    else check(gotQ.pop_front(), x);
  endtask

  // one header; model of delivery and class hold from ctl and mAddr
  task automatic rx(input logic [47:0] da, input logic [15:0] qv, input logic [7:0] pe, input logic [15:0] et);
    logic hit;
    hit = (da == mAddr || da == pfc_pkg::PAUSE_MCAST) && et == pfc_pkg::ETYPE_MAC_CTRL;
    @(posedge ref_clk);
    rxHdrValid <= 1; rxDestAddr <= da; rxEtherType <= et; rxOpcode <= pfc_pkg::OPC_PRIO_PAUSE;
    rxPrioEnable <= pe; rxQuanta <= {8{qv}};
    @(posedge ref_clk);
    rxHdrValid <= 0;
    @(negedge ref_clk);
    check(rxDeliverValid, 1);
    check(rxDeliver, !hit || (ctl[1] && ctl[0]));
    if (hit && ctl[0]) hold = (qv != 0) ? (hold | pe) : (hold & ~pe);
    @(negedge ref_clk);
    check(pauseReceiveRx, hold);
  endtask

  initial begin
    repeat (6) @(posedge ref_clk);
    nrst <= 1;
    rdc(pfc_pkg::REG_CTRL_ADDR, pfc_pkg::CTRL_RESET, 0);
    rdc(pfc_pkg::REG_QUANTA_ADDR, pfc_pkg::QUANTA_RESET, 0);
    rdc(16'h0010, 0, 1);
    rdc(pfc_pkg::REG_STATUS_ADDR, 0, 0);
    txQ = 16'($random(seed));
    wr(pfc_pkg::REG_QUANTA_ADDR, {16'h0002, txQ});
    for (int c = 0; c < 8; c++) begin
      @(posedge ref_clk);
      lat <= 4'($random(seed));
      pauseInsertTx[c] <= 1'b1;
      expect_req({1'b0, 3'(c), txQ});
      @(posedge ref_clk);
      pauseInsertTx[c] <= 1'b0;
      expect_req({1'b1, 3'(c), 16'h0000});
    end
    ctl = 32'h0000_FD05;
    wr(pfc_pkg::REG_CTRL_ADDR, ctl);
    @(posedge ref_clk);
    pauseInsertTx[1] <= 1'b1;
    repeat (20) @(posedge ref_clk);
    check(gotQ.size(), 0);
    pauseInsertTx[1] <= 1'b0;
    expect_req({1'b1, 3'd1, 16'h0000});
    // frame in flight delays the request
    @(posedge ref_clk);
    txFrameActive <= 1;
    pauseInsertTx[0] <= 1'b1;
    repeat (10) @(negedge ref_clk);
    check(ctrlReqValid, 0);
    @(posedge ref_clk);
    txFrameActive <= 0;
    expect_req({1'b0, 3'd0, txQ});
    ctl = 32'h0000_FF0D;
    wr(pfc_pkg::REG_CTRL_ADDR, ctl);
    repeat (3) expect_req({1'b0, 3'd0, txQ});
    @(posedge ref_clk);
    pauseInsertTx[0] <= 1'b0;
    repeat (60) @(posedge ref_clk);
    check(gotQ[$], {1'b1, 3'd0, 16'h0000});
    gotQ.delete();
    ctl = 32'h0000_FF05;
    wr(pfc_pkg::REG_CTRL_ADDR, ctl);
    for (int i = 0; i < 3; i++) begin
      mAddr = (i == 2) ? '1 : 48'({$random(seed), $random(seed)});
      mAddr[40] = (i != 0);
      wr(pfc_pkg::REG_ADDRL_ADDR, mAddr[31:0]);
      wr(pfc_pkg::REG_ADDRH_ADDR, {16'hFFFF, mAddr[47:32]});
      rdc(pfc_pkg::REG_ADDRH_ADDR, {16'h0000, mAddr[47:32]}, 0);
      rx(mAddr ^ 48'h1, 16'h0040, 8'h0F, pfc_pkg::ETYPE_MAC_CTRL);
      rx(mAddr, 16'h0040, 8'h0F, pfc_pkg::ETYPE_MAC_CTRL);
      rx(mAddr, 16'h0000, 8'h0F, pfc_pkg::ETYPE_MAC_CTRL);
    end
    q = 16'(2 + {$random(seed)} % 4);
    rx(mAddr, q, 8'h81, pfc_pkg::ETYPE_MAC_CTRL);
    repeat (2 * q - 3) @(negedge ref_clk);
    check(pauseReceiveRx, 8'h81);
    check(txHold, 8'h81);
    repeat (8) @(negedge ref_clk);
    check(pauseReceiveRx, 0);
    hold = 0;
    ctl = 32'h0000_FF07;
    wr(pfc_pkg::REG_CTRL_ADDR, ctl);
    rx(mAddr, 16'h0040, 8'h02, pfc_pkg::ETYPE_MAC_CTRL);
    rx(pfc_pkg::PAUSE_MCAST, 16'h0000, 8'h02, pfc_pkg::ETYPE_MAC_CTRL);
    ctl = 32'h0000_FF06;
    wr(pfc_pkg::REG_CTRL_ADDR, ctl);
    rx(mAddr, 16'h0040, 8'h04, pfc_pkg::ETYPE_MAC_CTRL);
    rx(mAddr, 16'h0040, 8'h04, 16'h0800);
    final_report;
  end

  // whole run is a few hundred cycles; this limit is 40000 cycles, about a hundred times that
  initial begin
    #400000;
    n_fail++;
    final_report;
  end
endmodule
`default_nettype wire
